// ### inc/fpam_pkg.sv
// Shared constants and types for the front-panel attenuation menu controller.
package fpam_pkg;

  // Clock rate and printed times.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DEB_MS = 10;
  localparam int unsigned STEP_MS = 1000;
  localparam int unsigned IDLE_SHORT_S = 12;
  localparam int unsigned IDLE_LONG_S = 30;

  // Cycle counts derived from the times above.
  localparam int unsigned DEB_CYC = DEB_MS * (CLK_HZ / 1000);
  localparam int unsigned STEP_CYC = STEP_MS * (CLK_HZ / 1000);
  localparam int unsigned IDLE_SHORT_CYC = IDLE_SHORT_S * CLK_HZ;
  localparam int unsigned IDLE_LONG_CYC = IDLE_LONG_S * CLK_HZ;

  // Gain is held as attenuation in 0.5 dB units: 20 is -10.0 dB, 140 is -70.0 dB.
  localparam logic [7:0] ATT_MIN = 8'h14;
  localparam logic [7:0] ATT_MAX = 8'h8c;
  localparam logic [7:0] ATT_DEF = 8'h14;
  localparam logic [5:0] OFF_MAX = 6'h3c;
  localparam logic [4:0] ADDR_MAX = 5'h1f;

  // Menu items, cursor positions and the version shown at power-up.
  localparam logic [2:0] ITEM_AUX0 = 3'h4;
  localparam logic [2:0] ITEM_REMOTE = 3'h4;
  localparam logic [2:0] ITEM_IFACE = 3'h5;
  localparam logic [2:0] ITEM_ADDR = 3'h6;
  localparam logic [2:0] ITEM_LAST = 3'h7;
  localparam logic [1:0] CUR_GAIN = 2'h0;
  localparam logic [1:0] CUR_OFF = 2'h1;
  localparam logic [1:0] CUR_R_CH = 2'h2;
  localparam logic [1:0] CUR_R_AUX = 2'h1;
  localparam logic [7:0] SW_VERSION = 8'h01; // Arbitrary value.

  typedef enum logic [2:0] {ST_LOAD, ST_LAMP, ST_VER, ST_GAINS, ST_RUN, ST_MENU, ST_SAVE} fpam_state_t;

  typedef struct packed {
    logic menu;
    logic left;
    logic right;
    logic up;
    logic down;
  } fpam_keys_t;

  typedef struct packed {
    logic [7:0] att;
    logic [5:0] off;
  } fpam_chan_t;

  typedef struct packed {
    fpam_chan_t [3:0] ch;
    logic remote_en;
    logic iface_sel;
    logic [4:0] bus_addr;
    logic net_rst_arm;
  } fpam_set_t;

  localparam fpam_chan_t CHAN_DEF = '{att: ATT_DEF, off: 6'h00};
  localparam fpam_set_t SET_DEF = '{ch: {4{CHAN_DEF}}, remote_en: 1'b0, iface_sel: 1'b0,
                                    bus_addr: 5'h00, net_rst_arm: 1'b0};

  typedef struct packed {
    logic level;
    logic [31:0] cnt;
    logic press;
  } fpam_deb_t;

  typedef struct packed {
    fpam_state_t st;
    logic [2:0] item;
    logic [1:0] cur;
    logic ans;
    fpam_set_t set;
    fpam_set_t snap;
    logic [31:0] tmr;
    logic nv_wr;
    logic net_rst;
    logic [1:0] f_s1;
    logic [1:0] f_s2;
    logic alarm;
  } fpam_top_t;

endpackage

// ### logic/fpam_debounce.sv
// Switch debouncer that turns a settled closure into a one-cycle press event.
`timescale 1ns/1ps
module fpam_debounce
  import fpam_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = DEB_CYC
)
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Raw switch level and press event.
  input wire logic raw,
  output logic press
);

  fpam_deb_t q;
  fpam_deb_t d;

  // The level is only accepted after it has been stable for the whole window, so contact chatter is ignored.
  always_comb
  begin
    d = q;
    d.press = 1'b0;
    if (raw != q.level)
    begin
      d.cnt = q.cnt + 32'd1;
      if (q.cnt >= DEB_CYCLES - 32'd1)
      begin
        d.level = raw;
        d.cnt = '0;
        d.press = raw;
      end
    end
    else
    begin
      d.cnt = '0;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign press = q.press;

  property p_press_once;
    @(posedge clk) disable iff (!rst_n) (ce && q.press) |=> !q.press;
  endproperty
  a_press_once: assert property (p_press_once) else $error("Press event lasted more than one cycle.");

endmodule

// ### logic/fpam_menu.sv
// Front-panel menu controller for a four-channel step attenuator.
// Overview of operation
// - Menus run channels one to four, remote, interface, address, network reset, then save.
// - Edits start with a select press and are stored only when confirmed at save prompt.
// - About 12 seconds without switch activity outside channel editing abandons the edit session.
// - Saved settings live in nonvolatile storage and are reloaded at power-up.
// - Power-up shows all segments, then version, then channel gains, then runs.
// - Horizontal switch moves the edit cursor one position left or right.
// - Vertical switch raises or lowers a numeric value being edited.
// - Vertical switch toggles non-numeric items whichever way it is moved.
// - Channel gain stays between -10.0 dB and -70.0 dB.
// - Each vertical actuation on gain changes it by 0.5 dB.
// - Channel offset ranges from 0 to 60 in 1 dB steps.
// - A changed offset immediately updates that channel's displayed gain.
// - Gain edits act on the attenuator at once; stored only after yes at save.
// - Yes at the save prompt stores; no restores pre-session settings.
// - About 30 seconds idle during gain/offset editing discards unsaved edits.
// - Within a channel menu the horizontal switch moves between gain and offset.
// - Select advances to next item; select on the return marker opens save prompt.
// - Alarm LED lights when either twelve-volt attenuator supply is out of range.
`timescale 1ns/1ps
module fpam_menu
  import fpam_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = DEB_CYC,
  parameter int unsigned STEP_CYCLES = STEP_CYC,
  parameter int unsigned IDLE_SHORT_CYCLES = IDLE_SHORT_CYC,
  parameter int unsigned IDLE_LONG_CYCLES = IDLE_LONG_CYC
)
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Front-panel switches, raw levels, high while operated.
  input wire fpam_keys_t sw_raw,
  // Supply fault inputs, high while the rail is out of range.
  input wire logic fault_pos12,
  input wire logic fault_neg12,
  // Nonvolatile storage.
  output logic nv_rd_req,
  input wire logic nv_rd_valid,
  input wire fpam_set_t nv_rd_data,
  output logic nv_wr_en,
  output fpam_set_t nv_wr_data,
  // Attenuator drive and auxiliary settings.
  output logic [3:0][7:0] atten_code,
  output logic remote_en,
  output logic iface_sel,
  output logic [4:0] bus_addr,
  output logic net_reset_pulse,
  // Display and indicators.
  output fpam_state_t disp_mode,
  output logic [2:0] disp_item,
  output logic [1:0] disp_cursor,
  output logic disp_answer,
  output logic [7:0] disp_version,
  output logic [3:0][8:0] disp_gain,
  output logic alarm_led
);

  fpam_top_t q;
  fpam_top_t d;
  logic [4:0] press;
  fpam_keys_t key;
  logic any_key;
  logic [1:0] c;
  logic [1:0] rpos;
  logic [31:0] lim;
  logic idle_hit;
  logic step_done;

  // One debouncer per switch.
  for (genvar i = 0; i < 5; i++)
  begin : g_deb
    fpam_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .raw(sw_raw[i]),
      .press(press[i])
    );
  end

  assign key = fpam_keys_t'(press);
  assign any_key = |press;

  // Helper terms for the sequencer.
  always_comb
  begin
    c = q.item[1:0];
    rpos = (q.item < ITEM_AUX0) ? CUR_R_CH : CUR_R_AUX;
    // Channel editing gets the longer grace period; everything else the shorter one.
    lim = (q.st == ST_MENU && q.item < ITEM_AUX0) ? IDLE_LONG_CYCLES : IDLE_SHORT_CYCLES;
    idle_hit = !any_key && (q.tmr >= lim - 32'd1);
    step_done = q.tmr >= STEP_CYCLES - 32'd1;
  end

  // Next-state logic for the menu sequencer, settings and alarm.
  always_comb
  begin
    d = q;
    d.nv_wr = 1'b0;
    d.net_rst = 1'b0;
    // Fault inputs pass two flops before the alarm flop.
    d.f_s1 = {fault_pos12, fault_neg12};
    d.f_s2 = q.f_s1;
    d.alarm = |q.f_s2;
    // Any press restarts the inactivity timer; it saturates so it never wraps into a false timeout.
    if (any_key)
      d.tmr = '0;
    else if (q.tmr != 32'hffffffff)
      d.tmr = q.tmr + 32'd1;
    unique case (q.st)
      ST_LOAD:
      begin
        if (nv_rd_valid)
        begin
          d.set = nv_rd_data;
          // A corrupted record must not drive an illegal attenuation.
          for (int k = 0; k < 4; k++)
          begin
            if (nv_rd_data.ch[k].att < ATT_MIN || nv_rd_data.ch[k].att > ATT_MAX || nv_rd_data.ch[k].off > OFF_MAX)
              d.set.ch[k] = CHAN_DEF;
          end
          d.set.net_rst_arm = 1'b0;
          d.st = ST_LAMP;
          d.tmr = '0;
        end
      end
      ST_LAMP, ST_VER, ST_GAINS:
      begin
        if (step_done)
        begin
          d.tmr = '0;
          d.st = (q.st == ST_LAMP) ? ST_VER : ((q.st == ST_VER) ? ST_GAINS : ST_RUN);
        end
      end
      ST_RUN:
      begin
        if (key.menu)
        begin
          d.snap = q.set;
          d.st = ST_MENU;
          d.item = 3'h0;
          d.cur = CUR_GAIN;
        end
      end
      ST_MENU:
      begin
        if (idle_hit)
        begin
          d.set = q.snap;
          d.st = ST_RUN;
        end
        else if (key.menu)
        begin
          if (q.cur == rpos || q.item == ITEM_LAST)
          begin
            d.st = ST_SAVE;
            d.ans = 1'b0;
          end
          else
          begin
            d.item = q.item + 3'h1;
            d.cur = CUR_GAIN;
          end
        end
        else if (key.right)
        begin
          if (q.cur < rpos)
            d.cur = q.cur + 2'h1;
        end
        else if (key.left)
        begin
          if (q.cur != 2'h0)
            d.cur = q.cur - 2'h1;
        end
        else if (key.up || key.down)
        begin
          // Edits land in the live settings at once, so the attenuator follows gain edits.
          if (q.item < ITEM_AUX0 && q.cur == CUR_GAIN)
          begin
            if (key.up && q.set.ch[c].att > ATT_MIN)
              d.set.ch[c].att = q.set.ch[c].att - 8'h01;
            else if (!key.up && q.set.ch[c].att < ATT_MAX)
              d.set.ch[c].att = q.set.ch[c].att + 8'h01;
          end
          else if (q.item < ITEM_AUX0 && q.cur == CUR_OFF)
          begin
            if (key.up && q.set.ch[c].off < OFF_MAX)
              d.set.ch[c].off = q.set.ch[c].off + 6'h01;
            else if (!key.up && q.set.ch[c].off != 6'h00)
              d.set.ch[c].off = q.set.ch[c].off - 6'h01;
          end
          else if (q.cur == CUR_GAIN && q.item == ITEM_ADDR)
          begin
            if (key.up && q.set.bus_addr < ADDR_MAX)
              d.set.bus_addr = q.set.bus_addr + 5'h01;
            else if (!key.up && q.set.bus_addr != 5'h00)
              d.set.bus_addr = q.set.bus_addr - 5'h01;
          end
          else if (q.cur == CUR_GAIN && q.item == ITEM_REMOTE)
            d.set.remote_en = !q.set.remote_en;
          else if (q.cur == CUR_GAIN && q.item == ITEM_IFACE)
            d.set.iface_sel = !q.set.iface_sel;
          else if (q.cur == CUR_GAIN && q.item == ITEM_LAST)
            d.set.net_rst_arm = !q.set.net_rst_arm;
        end
      end
      ST_SAVE:
      begin
        if (idle_hit)
        begin
          d.set = q.snap;
          d.st = ST_RUN;
        end
        else if (key.menu)
        begin
          d.st = ST_RUN;
          if (q.ans)
          begin
            d.nv_wr = 1'b1;
            d.net_rst = q.set.net_rst_arm;
            d.set.net_rst_arm = 1'b0;
          end
          else
            d.set = q.snap;
        end
        else if (key.up || key.down)
          d.ans = !q.ans;
      end
      default:
        d.st = ST_LOAD;
    endcase
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.set <= SET_DEF;
      q.snap <= SET_DEF;
    end
    else if (ce)
      q <= d;
  end

  // Outputs, all but the version taken from the state register.
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      atten_code[k] = q.set.ch[k].att;
      disp_gain[k] = {1'b0, q.set.ch[k].att} + {2'b00, q.set.ch[k].off, 1'b0};
    end
  end

  assign nv_rd_req = (q.st == ST_LOAD);
  assign nv_wr_en = q.nv_wr;
  assign nv_wr_data = q.set;
  assign remote_en = q.set.remote_en;
  assign iface_sel = q.set.iface_sel;
  assign bus_addr = q.set.bus_addr;
  assign net_reset_pulse = q.net_rst;
  assign disp_mode = q.st;
  assign disp_item = q.item;
  assign disp_cursor = q.cur;
  assign disp_answer = q.ans;
  assign disp_version = SW_VERSION;
  assign alarm_led = q.alarm;

  property p_gain_range;
    @(posedge clk) disable iff (!rst_n) q.set.ch[0].att >= ATT_MIN && q.set.ch[0].att <= ATT_MAX
      && q.set.ch[3].att >= ATT_MIN && q.set.ch[3].att <= ATT_MAX;
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("Channel gain left its range.");

  property p_gain_step;
    @(posedge clk) disable iff (!rst_n)
      (ce && q.st == ST_MENU && q.item < ITEM_AUX0 && q.cur == CUR_GAIN && key.up && !key.menu
       && !key.left && !key.right && q.set.ch[c].att > ATT_MIN)
      |=> q.set.ch[$past(c)].att == $past(q.set.ch[c].att) - 8'h01;
  endproperty
  a_gain_step: assert property (p_gain_step) else $error("Gain did not rise by one half-dB step.");

  property p_off_disp;
    @(posedge clk) disable iff (!rst_n)
      (ce && q.st == ST_MENU && q.item == 3'h0 && q.cur == CUR_OFF && key.up && !key.menu
       && !key.left && !key.right && q.set.ch[0].off < OFF_MAX)
      |=> disp_gain[0] == $past(disp_gain[0]) + 9'h002;
  endproperty
  a_off_disp: assert property (p_off_disp) else $error("Displayed gain did not follow offset.");

  property p_off_range;
    @(posedge clk) disable iff (!rst_n) q.set.ch[1].off <= OFF_MAX && q.set.ch[2].off <= OFF_MAX;
  endproperty
  a_off_range: assert property (p_off_range) else $error("Offset exceeded its maximum.");

  property p_save_no;
    @(posedge clk) disable iff (!rst_n)
      (ce && q.st == ST_SAVE && key.menu && !q.ans) |=> (q.set == $past(q.snap)) && !nv_wr_en && q.st == ST_RUN;
  endproperty
  a_save_no: assert property (p_save_no) else $error("Declined save did not restore settings.");

  property p_wr_cause;
    @(posedge clk) disable iff (!rst_n) nv_wr_en |-> $past(q.st) == ST_SAVE && $past(q.ans) && $past(key.menu);
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("Storage written without a confirmed save.");

  property p_enter_menu;
    @(posedge clk) disable iff (!rst_n)
      (q.st == ST_MENU && $past(q.st) != ST_MENU) |-> $past(q.st) == ST_RUN && $past(key.menu);
  endproperty
  a_enter_menu: assert property (p_enter_menu) else $error("Menu entered without a select press.");

  property p_return_save;
    @(posedge clk) disable iff (!rst_n)
      (ce && q.st == ST_MENU && key.menu && q.cur == rpos) |=> q.st == ST_SAVE && !q.ans;
  endproperty
  a_return_save: assert property (p_return_save) else $error("Return marker did not open save prompt.");

  property p_cursor_right;
    @(posedge clk) disable iff (!rst_n)
      (ce && q.st == ST_MENU && key.right && !key.menu && q.cur < rpos) |=> q.cur == $past(q.cur) + 2'h1;
  endproperty
  a_cursor_right: assert property (p_cursor_right) else $error("Cursor did not move right.");

  property p_alarm;
    @(posedge clk) disable iff (!rst_n) (ce && fault_pos12)[*3] |=> alarm_led;
  endproperty
  a_alarm: assert property (p_alarm) else $error("Alarm missed a supply fault.");

endmodule

// ### tb/fpam_nv_model.sv
// Behavioural nonvolatile settings store that answers the controller's load and store requests.
`timescale 1ns/1ps
module fpam_nv_model
  import fpam_pkg::*;
#(
  parameter int unsigned LAT = 3,
  parameter fpam_set_t INIT = SET_DEF
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Load side.
  input wire logic nv_rd_req,
  output logic nv_rd_valid,
  output fpam_set_t nv_rd_data,
  // Store side.
  input wire logic nv_wr_en,
  input wire fpam_set_t nv_wr_data
);
  fpam_set_t mem = INIT;
  logic [7:0] cnt_q = 8'h00;
  logic valid_q = 1'b0;
  int n_wr = 0;

  // Outside the valid cycle the data lines show junk, so a late sample cannot pass by luck.
  assign nv_rd_valid = valid_q;
  assign nv_rd_data = valid_q ? mem : ~mem;

  // The record survives reset, as storage keeps it across power loss.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= 8'h00;
      valid_q <= 1'b0;
    end
    else
    begin
      valid_q <= 1'b0;
      if (nv_rd_req && !valid_q)
      begin
        if (cnt_q == 8'(LAT))
        begin
          valid_q <= 1'b1;
          cnt_q <= 8'h00;
        end
        else
          cnt_q <= cnt_q + 8'h01;
      end
    end
    if (nv_wr_en)
    begin
      mem <= nv_wr_data;
      n_wr <= n_wr + 1;
    end
  end
endmodule

// ### tb/fpam_menu_test.sv
// Self-checking testbench for the front-panel menu controller.
`timescale 1ns/1ps
module fpam_menu_test;
  import fpam_pkg::*;
  localparam int K_MENU = 4;
  localparam int K_LEFT = 3;
  localparam int K_RIGHT = 2;
  localparam int K_UP = 1;
  localparam int K_DOWN = 0;
  localparam fpam_set_t INIT = '{ch: {CHAN_DEF, CHAN_DEF, fpam_chan_t'{att: 8'h90, off: 6'h00},
                                      fpam_chan_t'{att: 8'h20, off: 6'h05}},
                                 remote_en: 1'b1, iface_sel: 1'b0, bus_addr: 5'h00, net_rst_arm: 1'b0};
  logic clk;
  logic rst_n;
  logic ce;
  fpam_keys_t sw_raw;
  logic fault_pos12;
  logic fault_neg12;
  logic nv_rd_req;
  logic nv_rd_valid;
  fpam_set_t nv_rd_data;
  logic nv_wr_en;
  fpam_set_t nv_wr_data;
  logic [3:0][7:0] atten_code;
  logic remote_en;
  logic iface_sel;
  logic net_reset_pulse;
  logic [4:0] bus_addr;
  fpam_state_t disp_mode;
  logic [2:0] disp_item;
  logic [1:0] disp_cursor;
  logic disp_answer;
  logic [7:0] disp_version;
  logic [3:0][8:0] disp_gain;
  logic alarm_led;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n_net = 0;

  // Short counts keep the run brief; every expectation below follows them.
  fpam_menu #(.DEB_CYCLES(4), .STEP_CYCLES(8), .IDLE_SHORT_CYCLES(40), .IDLE_LONG_CYCLES(100)) u_fpam_menu (
    .clk(clk), .rst_n(rst_n), .ce(ce), .sw_raw(sw_raw), .fault_pos12(fault_pos12), .fault_neg12(fault_neg12),
    .nv_rd_req(nv_rd_req), .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data), .nv_wr_en(nv_wr_en),
    .nv_wr_data(nv_wr_data), .atten_code(atten_code), .remote_en(remote_en), .iface_sel(iface_sel),
    .bus_addr(bus_addr), .net_reset_pulse(net_reset_pulse), .disp_mode(disp_mode), .disp_item(disp_item),
    .disp_cursor(disp_cursor),
    .disp_answer(disp_answer), .disp_version(disp_version), .disp_gain(disp_gain), .alarm_led(alarm_led));

  fpam_nv_model #(.LAT(3), .INIT(INIT)) u_fpam_nv_model (
    .clk(clk), .rst_n(rst_n), .nv_rd_req(nv_rd_req), .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data),
    .nv_wr_en(nv_wr_en), .nv_wr_data(nv_wr_data));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // Counts network-reset pulses; each stands for one registered cycle, so a posedge sample sees it once.
  always @(posedge clk)
  begin
    if (net_reset_pulse)
      n_net <= n_net + 1;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 12000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // Operates one switch n times, holding and releasing each longer than the debounce time.
  task automatic press(input int k, input int n);
    repeat (n)
    begin
      @(posedge clk);
      sw_raw[k] <= 1'b1;
      repeat (6) @(posedge clk);
      sw_raw[k] <= 1'b0;
      repeat (6) @(posedge clk);
    end
    @(negedge clk);
  endtask

  task automatic wait_mode(input fpam_state_t m, input int lim);
    int i;
    i = 0;
    while (disp_mode !== m && i < lim)
    begin
      @(negedge clk);
      i++;
    end
    chk("disp_mode", m, disp_mode);
  endtask

  task automatic boot(input logic [7:0] a0, input logic [8:0] g0);
    wait_mode(ST_LAMP, 30);
    chk("atten0", a0, atten_code[0]);
    chk("gain0", g0, disp_gain[0]);
    chk("atten1", ATT_DEF, atten_code[1]);
    wait_mode(ST_VER, 12);
    chk("version", SW_VERSION, disp_version);
    wait_mode(ST_GAINS, 12);
    wait_mode(ST_RUN, 12);
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    sw_raw = '0;
    fault_pos12 = 1'b0;
    fault_neg12 = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    boot(8'h20, 9'h02a);
    chk("remote", 1'b1, remote_en);
    // Edit channel one through both clamps and both fields, then keep it.
    press(K_MENU, 1);
    chk("mode", ST_MENU, disp_mode);
    chk("item", 3'h0, disp_item);
    press(K_UP, 1);
    chk("atten0", 8'h1f, atten_code[0]);
    chk("writes", 0, u_fpam_nv_model.n_wr);
    press(K_UP, 12);
    chk("atten0", ATT_MIN, atten_code[0]);
    press(K_DOWN, 125);
    chk("atten0", ATT_MAX, atten_code[0]);
    press(K_RIGHT, 1);
    chk("cursor", CUR_OFF, disp_cursor);
    press(K_UP, 62);
    chk("gain0", 9'h104, disp_gain[0]);
    press(K_DOWN, 1);
    chk("gain0", 9'h102, disp_gain[0]);
    press(K_LEFT, 1);
    chk("cursor", CUR_GAIN, disp_cursor);
    press(K_RIGHT, 3);
    chk("cursor", CUR_R_CH, disp_cursor);
    press(K_MENU, 1);
    chk("mode", ST_SAVE, disp_mode);
    chk("answer", 1'b0, disp_answer);
    press(K_UP, 1);
    chk("answer", 1'b1, disp_answer);
    press(K_UP, 1);
    chk("answer", 1'b0, disp_answer);
    press(K_DOWN, 1);
    chk("answer", 1'b1, disp_answer);
    press(K_MENU, 1);
    chk("mode", ST_RUN, disp_mode);
    chk("writes", 1, u_fpam_nv_model.n_wr);
    chk("stored", ATT_MAX, u_fpam_nv_model.mem.ch[0].att);
    // Walk every item, change some, then refuse at the save prompt.
    press(K_MENU, 1);
    press(K_UP, 1);
    chk("atten0", 8'h8b, atten_code[0]);
    for (int i = 1; i < 8; i++)
    begin
      press(K_MENU, 1);
      chk("item", i, disp_item);
      if (i == 4)
      begin
        press(K_UP, 1);
        chk("remote", 1'b0, remote_en);
        press(K_DOWN, 1);
        chk("remote", 1'b1, remote_en);
      end
      if (i == 5)
      begin
        press(K_DOWN, 1);
        chk("iface", 1'b1, iface_sel);
      end
      if (i == 6)
      begin
        press(K_UP, 1);
        chk("bus_addr", 5'h01, bus_addr);
      end
      if (i == 7)
        press(K_UP, 1);
    end
    press(K_MENU, 1);
    chk("mode", ST_SAVE, disp_mode);
    press(K_MENU, 1);
    chk("atten0", ATT_MAX, atten_code[0]);
    chk("bus_addr", 5'h00, bus_addr);
    chk("writes", 1, u_fpam_nv_model.n_wr);
    chk("iface", 1'b0, iface_sel);
    chk("net_reset", 0, n_net);
    // Arm the network reset on the last item and confirm: one store and one pulse.
    press(K_MENU, 8);
    chk("item", ITEM_LAST, disp_item);
    press(K_UP, 1);
    press(K_MENU, 1);
    chk("mode", ST_SAVE, disp_mode);
    press(K_UP, 1);
    press(K_MENU, 1);
    chk("net_reset", 1, n_net);
    chk("writes", 2, u_fpam_nv_model.n_wr);
    // Walk away while editing a gain: the longer idle limit applies.
    press(K_MENU, 1);
    press(K_UP, 1);
    repeat (60) @(negedge clk);
    chk("mode", ST_MENU, disp_mode);
    wait_mode(ST_RUN, 60);
    chk("atten0", ATT_MAX, atten_code[0]);
    // Walk away on a non-channel item: the shorter limit applies.
    press(K_MENU, 5);
    press(K_UP, 1);
    chk("remote", 1'b0, remote_en);
    repeat (20) @(negedge clk);
    chk("mode", ST_MENU, disp_mode);
    wait_mode(ST_RUN, 40);
    chk("remote", 1'b1, remote_en);
    // Each rail fault lights the alarm after synchronising, and clears.
    for (int r = 0; r < 2; r++)
    begin
      for (int lv = 1; lv >= 0; lv--)
      begin
        @(posedge clk);
        if (r == 0)
          fault_pos12 <= lv[0];
        else
          fault_neg12 <= lv[0];
        @(negedge clk);
        chk("alarm_early", !lv[0], alarm_led);
        repeat (6) @(negedge clk);
        chk("alarm", lv[0], alarm_led);
      end
    end
    // With the clock enable low the debouncers are frozen, so a select press never reaches the sequencer.
    @(posedge clk);
    ce <= 1'b0;
    press(K_MENU, 1);
    chk("mode", ST_RUN, disp_mode);
    @(posedge clk);
    ce <= 1'b1;
    // Power returns: the kept settings come back.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    boot(ATT_MAX, 9'h102);
    conclude();
  end
endmodule
